// ### pkg/thermal_limit_pkg.sv
// Shared constants and carrier types for the thermal limit and alarm block.
// Assumes a single 10 MHz system clock and an AXI4-Lite register master.
package thermal_limit_pkg;

  // Clock and conversion pacing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_GAP_NS = 1000;
  localparam int CONV_GAP_CYCLES = (CONV_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] GAP_LAST = 8'(CONV_GAP_CYCLES - 1);

  // Channel count and bus widths.
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_HIGH_BASE = 6'h20;
  localparam logic [5:0] IDX_R3_HIGH_UPPER = 6'h26;
  localparam logic [5:0] IDX_R3_HIGH_LOWER = 6'h27;
  localparam logic [5:0] IDX_LOW_UPPER = 6'h30;
  localparam logic [5:0] IDX_LOW_LOWER = 6'h31;
  localparam logic [5:0] IDX_HIGH_STATUS = 6'h32;
  localparam logic [5:0] IDX_LOW_STATUS = 6'h33;
  localparam logic [5:0] IDX_ALARM_MASK = 6'h34;
  localparam logic [5:0] IDX_CH_ENABLE = 6'h35;
  localparam logic [5:0] IDX_DIODE_FAULT = 6'h36;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h38;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h39;

  // Values after reset.
  localparam logic [7:0] RST_HIGH_UPPER = 8'h7f;
  localparam logic [3:0] RST_HIGH_LOWER = 4'h0;
  localparam logic [7:0] RST_LOW_UPPER = 8'hc9;
  localparam logic [3:0] RST_LOW_LOWER = 4'h0;
  localparam logic [3:0] RST_STATUS = 4'h0;
  localparam logic [3:0] RST_ALARM_MASK = 4'h0;
  localparam logic [3:0] RST_CH_ENABLE = 4'hf;
  localparam logic [7:0] RST_IRQ = 8'h00;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_START = 2'b01,
    SEQ_WAIT = 2'b10
  } seq_state_e;

  // One conversion result from the measurement front end.
  typedef struct packed {
    logic [15:0] temp;
    logic diode_fault;
  } conv_result_s;

endpackage : thermal_limit_pkg

// ### src/thermal_limit_alarm_logic.sv
// Limit registers, thermal status, alarm masking and channel sequencing of a four-channel monitor.
// Assumes an AXI4-Lite master on CLK_SYS and a converter that answers each start with one done pulse.
`timescale 1ns/1ps

module thermal_limit_alarm_logic
  import thermal_limit_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic CONV_START,
  output logic [1:0] CONV_CHANNEL,
  output logic FAULT_TEST_EN,
  input wire logic CONV_DONE,
  input wire conv_result_s CONV_RESULT,
  input wire logic THERMAL_ALARM_OUTPUT_IN,
  output logic THERMAL_ALARM_OUTPUT_OUT,
  output logic THERMAL_ALARM_OUTPUT_OE_N,
  output logic IRQ
);

  // Register state.
  logic [7:0] high_upper [NUM_CH];
  logic [3:0] high_lower [NUM_CH];
  logic [7:0] low_upper;
  logic [3:0] low_lower;
  logic [3:0] high_status;
  logic [3:0] low_status;
  logic [3:0] alarm_mask;
  logic [3:0] ch_enable;
  logic [3:0] diode_fault;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;

  // Write channel state.
  logic aw_held;
  logic w_held;
  logic [5:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane;

  // Sequencer state.
  seq_state_e seq_state;
  seq_state_e next_seq_state;
  logic [1:0] cur_ch;
  logic [7:0] gap_count;

  // Picks the next enabled channel after the current one, wrapping around.
  function automatic logic [2:0] pick_next(input logic [1:0] cur, input logic [3:0] en);
    logic [2:0] found;
    logic [1:0] cand;
    found = 3'b000;
    cand = cur;
    for (int i = 1; i <= NUM_CH; i++)
    begin
      cand = 2'(cur + 2'(i));
      if (!found[2] && en[cand])
      begin
        found = {1'b1, cand};
      end
    end
    return found;
  endfunction : pick_next

  // Maps a register index to a high limit channel and byte half.
  function automatic logic [3:0] high_slot(input logic [5:0] idx);
    logic hit;
    hit = (idx >= IDX_HIGH_BASE) && (idx <= IDX_R3_HIGH_LOWER);
    return {hit, idx[2:1], idx[0]};
  endfunction : high_slot

  // Write decode, taken when both halves of a write are held and no response is pending.
  wire wr_fire = aw_held && w_held && !S_AXI_BVALID;
  wire wr_ok = wr_fire && wr_lane;
  wire [3:0] wr_slot = high_slot(wr_idx);
  wire [5:0] rd_idx = S_AXI_ARADDR[7:2];
  wire [3:0] rd_slot = high_slot(rd_idx);
  wire wr_mapped = wr_slot[3] || (wr_idx >= IDX_LOW_UPPER && wr_idx <= IDX_DIODE_FAULT)
                   || wr_idx == IDX_IRQ_STATUS || wr_idx == IDX_IRQ_MASK;

  // Conversion result compare against the stored limits, both in the same sixteen-bit form.
  wire [1:0] res_ch = cur_ch;
  wire signed [15:0] res_temp = CONV_RESULT.temp;
  wire signed [15:0] res_high = {high_upper[res_ch], high_lower[res_ch], 4'h0};
  wire signed [15:0] res_low = {low_upper, low_lower, 4'h0};
  wire res_take = (seq_state == SEQ_WAIT) && CONV_DONE;
  wire res_over = res_temp > res_high;
  wire res_under = res_temp < res_low;
  wire [3:0] ch_bit = 4'(4'b0001 << res_ch);

  // Next flag values and the events that raise interrupt bits.
  wire [3:0] next_high_status = res_take ? (res_over ? (high_status | ch_bit) : (high_status & ~ch_bit))
                                         : high_status;
  wire [3:0] next_low_status = res_take ? (res_under ? (low_status | ch_bit) : (low_status & ~ch_bit))
                                        : low_status;
  wire [7:0] irq_events = {next_low_status & ~low_status, next_high_status & ~high_status};
  wire next_alarm = |((high_status | low_status) & ~alarm_mask);
  wire [2:0] next_pick = pick_next(cur_ch, ch_enable);
  wire gap_done = gap_count == GAP_LAST;

  // Sequencer transitions; a channel whose bit is clear is never started.
  always_comb
  begin
    next_seq_state = seq_state;
    unique case (seq_state)
      SEQ_IDLE: if (gap_done && next_pick[2]) next_seq_state = SEQ_START;
      SEQ_START: next_seq_state = SEQ_WAIT;
      SEQ_WAIT: if (CONV_DONE) next_seq_state = SEQ_IDLE;
      default: next_seq_state = SEQ_IDLE;
    endcase
  end

  // Gap counter between conversions, the slow pacing enable.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      gap_count <= 8'h00;
    else if (seq_state != SEQ_IDLE || gap_done)
      gap_count <= 8'h00;
    else
      gap_count <= gap_count + 8'h01;
  end

  // Sequencer state, channel select and converter strobes.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      seq_state <= SEQ_IDLE;
      cur_ch <= 2'b11;
      CONV_START <= 1'b0;
      FAULT_TEST_EN <= 1'b0;
    end
    else
    begin
      seq_state <= next_seq_state;
      CONV_START <= (seq_state == SEQ_IDLE) && (next_seq_state == SEQ_START);
      if (seq_state == SEQ_IDLE && next_seq_state == SEQ_START)
      begin
        cur_ch <= next_pick[1:0];
        FAULT_TEST_EN <= next_pick[1:0] != 2'b00;
      end
      else if (seq_state == SEQ_WAIT && CONV_DONE)
        FAULT_TEST_EN <= 1'b0;
    end
  end

  assign CONV_CHANNEL = cur_ch;

  // Status flags, diode faults and the alarm pin; the pin is only ever pulled low.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      high_status <= RST_STATUS;
      low_status <= RST_STATUS;
      diode_fault <= RST_STATUS;
      THERMAL_ALARM_OUTPUT_OE_N <= 1'b1;
      THERMAL_ALARM_OUTPUT_OUT <= 1'b0;
    end
    else
    begin
      high_status <= next_high_status;
      low_status <= next_low_status;
      if (res_take && res_ch != 2'b00 && FAULT_TEST_EN)
        diode_fault[res_ch] <= CONV_RESULT.diode_fault;
      THERMAL_ALARM_OUTPUT_OE_N <= ~next_alarm;
      THERMAL_ALARM_OUTPUT_OUT <= 1'b0;
    end
  end

  // High limit storage; the upper byte is kept as written, the lower byte keeps only its top nibble.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        high_upper[c] <= RST_HIGH_UPPER;
        high_lower[c] <= RST_HIGH_LOWER;
      end
    end
    else if (wr_ok && wr_slot[3])
    begin
      if (!wr_slot[0])
        high_upper[wr_slot[2:1]] <= wr_byte;
      else
        high_lower[wr_slot[2:1]] <= wr_byte[7:4];
    end
  end

  // Shared low limit, mask and enable bytes; reserved bits are never stored.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      low_upper <= RST_LOW_UPPER;
      low_lower <= RST_LOW_LOWER;
      alarm_mask <= RST_ALARM_MASK;
      ch_enable <= RST_CH_ENABLE;
      irq_mask <= RST_IRQ;
    end
    else if (wr_ok)
    begin
      if (wr_idx == IDX_LOW_UPPER)
        low_upper <= wr_byte;
      if (wr_idx == IDX_LOW_LOWER)
        low_lower <= wr_byte[7:4];
      if (wr_idx == IDX_ALARM_MASK)
        alarm_mask <= wr_byte[3:0];
      if (wr_idx == IDX_CH_ENABLE)
        ch_enable <= wr_byte[3:0];
      if (wr_idx == IDX_IRQ_MASK)
        irq_mask <= wr_byte;
    end
  end

  // Sticky interrupt bits; a new event wins over a write-one clear in the same cycle.
  wire [7:0] irq_clear = (wr_ok && wr_idx == IDX_IRQ_STATUS) ? wr_byte : 8'h00;
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      irq_status <= RST_IRQ;
      IRQ <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      IRQ <= |(((irq_status & ~irq_clear) | irq_events) & irq_mask);
    end
  end

  // Write address and data capture; each is held until the write response is accepted.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_idx <= 6'h00;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        wr_idx <= S_AXI_AWADDR[7:2];
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        wr_byte <= S_AXI_WDATA[7:0];
        wr_lane <= S_AXI_WSTRB[0];
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Read selection; reserved bits and the zero low nibble of fraction bytes read as zero.
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (rd_slot[3])
      rd_byte = rd_slot[0] ? {high_lower[rd_slot[2:1]], 4'h0} : high_upper[rd_slot[2:1]];
    else
    begin
      unique case (rd_idx)
        IDX_LOW_UPPER: rd_byte = low_upper;
        IDX_LOW_LOWER: rd_byte = {low_lower, 4'h0};
        IDX_HIGH_STATUS: rd_byte = {4'h0, high_status};
        IDX_LOW_STATUS: rd_byte = {4'h0, low_status};
        IDX_ALARM_MASK: rd_byte = {4'h0, alarm_mask};
        IDX_CH_ENABLE: rd_byte = {4'h0, ch_enable};
        IDX_DIODE_FAULT: rd_byte = {4'h0, diode_fault[3:1], 1'b0};
        IDX_IRQ_STATUS: rd_byte = irq_status;
        IDX_IRQ_MASK: rd_byte = irq_mask;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Read channel; the answer is registered one cycle after the address is taken.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h00_0000, rd_byte};
      S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Checks kept beside the logic they guard.
  remote3_reset_a: assert property (@(posedge CLK_SYS) $fell(RST) |->
    high_upper[3] == 8'h7f && high_lower[3] == 4'h0) else $error("Remote 3 high limit reset wrong.");

  low_reset_a: assert property (@(posedge CLK_SYS) $fell(RST) |->
    low_upper == 8'hc9 && low_lower == 4'h0) else $error("Shared low limit reset wrong.");

  high_flag_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    res_take |=> high_status[$past(res_ch)] == $past(res_over)) else $error("High flag not from compare.");

  low_flag_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    res_take |=> low_status[$past(res_ch)] == $past(res_under)) else $error("Low flag not from compare.");

  alarm_pin_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    ##1 THERMAL_ALARM_OUTPUT_OE_N == !$past(|((high_status | low_status) & ~alarm_mask)))
    else $error("Alarm pin disagrees with masked flags.");

  mask_blocks_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (alarm_mask == 4'hf)[*2] |-> THERMAL_ALARM_OUTPUT_OE_N) else $error("Masked alarm still driven.");

  skip_disabled_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CONV_START |-> |($past(ch_enable) & 4'(4'b0001 << CONV_CHANNEL)))
    else $error("Disabled channel was started.");

  fault_test_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(FAULT_TEST_EN) |-> CONV_CHANNEL != 2'b00 && CONV_START) else $error("Fault test off a remote start.");

  reserved_zero_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    S_AXI_ARVALID && S_AXI_ARREADY && (rd_idx == IDX_ALARM_MASK || rd_idx == IDX_CH_ENABLE)
    |=> S_AXI_RDATA[7:4] == 4'h0) else $error("Mask or enable reserved bits not zero.");

  enable_reset_a: assert property (@(posedge CLK_SYS) $fell(RST) |->
    ch_enable == 4'hf && alarm_mask == 4'h0) else $error("Enable or mask reset wrong.");

  read_answer_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("Read answer late or upper bits set.");

  status_reserved_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    S_AXI_ARVALID && S_AXI_ARREADY && (rd_idx == IDX_HIGH_STATUS || rd_idx == IDX_LOW_STATUS)
    |=> S_AXI_RDATA[7:4] == 4'h0) else $error("Status reserved bits not zero.");

  gap_pace_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $fell(CONV_START) |-> !CONV_START[*8]) else $error("Conversions started too close.");

endmodule : thermal_limit_alarm_logic

// ### dv/conv_model.sv
// Behavioural temperature converter that answers the limit block's start pulses.
// Assumes the bench supplies one reading and one diode fault bit per channel.
`timescale 1ns/1ps
module conv_model
  import thermal_limit_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] channel,
  input wire logic [63:0] temps,
  input wire logic [3:0] faults,
  input wire logic [3:0] delay,
  output logic done,
  output conv_result_s result
);
  logic busy;
  logic [1:0] ch;
  logic [3:0] wait_cnt;

  // Answers each start once after the set delay; the result bus toggles between answers so stale data never matches.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      ch <= 2'd0;
      wait_cnt <= 4'h0;
      done <= 1'b0;
      result <= '0;
    end
    else
    begin
      done <= 1'b0;
      result <= ~result;
      if (start)
      begin
        busy <= 1'b1;
        ch <= channel;
        wait_cnt <= delay;
      end
      else if (busy && wait_cnt == 4'h0)
      begin
        done <= 1'b1;
        result <= '{temp: temps[ch*16 +: 16], diode_fault: faults[ch]};
        busy <= 1'b0;
      end
      else if (busy)
      begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule : conv_model

// ### dv/thermal_limit_alarm_logic_bench.sv
// Self-checking bench for the limit, status, alarm and channel enable logic.
// Assumes the package constants and the converter model beside this file.
`timescale 1ns/1ps
module thermal_limit_alarm_logic_bench
  import thermal_limit_pkg::*;
;
  logic clk_sys;
  logic rst;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb, faults, delay;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, conv_channel;
  logic conv_start, fault_test_en, conv_done, alarm_out, alarm_oe_n, irq;
  conv_result_s conv_result;
  logic [63:0] temps;
  wire alarm_pin;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // The alarm line has a pull-up; the block only pulls it low.
  assign alarm_pin = alarm_oe_n ? 1'b1 : alarm_out;

  thermal_limit_alarm_logic thermal_limit_alarm_logic_inst (.CLK_SYS(clk_sys), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CONV_START(conv_start), .CONV_CHANNEL(conv_channel),
    .FAULT_TEST_EN(fault_test_en), .CONV_DONE(conv_done), .CONV_RESULT(conv_result),
    .THERMAL_ALARM_OUTPUT_IN(alarm_pin), .THERMAL_ALARM_OUTPUT_OUT(alarm_out),
    .THERMAL_ALARM_OUTPUT_OE_N(alarm_oe_n), .IRQ(irq));

  conv_model conv_model_inst (.clk(clk_sys), .rst(rst), .start(conv_start), .channel(conv_channel),
    .temps(temps), .faults(faults), .delay(delay), .done(conv_done), .result(conv_result));

  // Free-running 10 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Cuts a hung run short.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Write cycle: address and data offered together, each released when taken.
  task automatic axi_write(input logic [5:0] idx, input logic [7:0] val, output logic [1:0] resp);
    int n;
    n = 0;
    resp = 2'b11;
    @(posedge clk_sys);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100)
    begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    check(n, (n < 100) ? n : 0);
  endtask : axi_write

  // Read cycle: address held until taken, data taken at the edge that sees rvalid.
  task automatic axi_read(input logic [5:0] idx, output logic [31:0] data, output logic [1:0] resp);
    int n;
    n = 0;
    data = 32'hffff_ffff;
    resp = 2'b11;
    @(posedge clk_sys);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100)
    begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    check(n, (n < 100) ? n : 0);
  endtask : axi_read

  task automatic wr(input logic [5:0] idx, input logic [7:0] val);
    logic [1:0] r;
    axi_write(idx, val, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(idx, d, r);
    check(d, {24'h0, exp});
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : rd

  // Waits for a fresh conversion of one channel, then lets status and alarm settle.
  task automatic wait_conv(input logic [1:0] ch);
    int n;
    logic started;
    n = 0;
    started = 1'b0;
    while (n < 300)
    begin
      @(posedge clk_sys);
      n++;
      if (conv_start && conv_channel == ch)
      begin
        started = 1'b1;
        check({31'h0, fault_test_en}, {31'h0, ch != 2'd0});
      end
      else if (started && conv_done)
        break;
    end
    check(n, (n < 300) ? n : 0);
    repeat (2) @(posedge clk_sys);
  endtask : wait_conv

  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
  endtask : do_reset

  task automatic reset_values();
    logic [31:0] d;
    logic [1:0] r;
    rd(IDX_R3_HIGH_UPPER, 8'h7f);
    rd(IDX_R3_HIGH_LOWER, 8'h00);
    rd(IDX_LOW_UPPER, 8'hc9);
    rd(IDX_LOW_LOWER, 8'h00);
    rd(IDX_HIGH_STATUS, 8'h00);
    rd(IDX_LOW_STATUS, 8'h00);
    rd(IDX_ALARM_MASK, 8'h00);
    rd(IDX_CH_ENABLE, 8'h0f);
    check({31'h0, alarm_pin}, 32'h1);
    axi_read(6'h3f, d, r);
    check(d, 32'h0000_0000);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_write(6'h3f, 8'h55, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : reset_values

  task automatic access_rules();
    wr(IDX_R3_HIGH_UPPER, 8'h5a);
    rd(IDX_R3_HIGH_UPPER, 8'h5a);
    wr(IDX_R3_HIGH_LOWER, 8'hff);
    rd(IDX_R3_HIGH_LOWER, 8'hf0);
    wr(IDX_LOW_LOWER, 8'hff);
    rd(IDX_LOW_LOWER, 8'hf0);
    wr(IDX_LOW_LOWER, 8'h00);
    wr(IDX_HIGH_STATUS, 8'hff);
    rd(IDX_HIGH_STATUS, 8'h00);
    wr(IDX_LOW_STATUS, 8'hff);
    rd(IDX_LOW_STATUS, 8'h00);
    wr(IDX_ALARM_MASK, 8'hff);
    rd(IDX_ALARM_MASK, 8'h0f);
    wr(IDX_ALARM_MASK, 8'h00);
    wr(IDX_CH_ENABLE, 8'hff);
    rd(IDX_CH_ENABLE, 8'h0f);
    // A write without byte lane 0 is answered but leaves the register alone.
    wstrb <= 4'he;
    wr(IDX_CH_ENABLE, 8'h00);
    wstrb <= 4'hf;
    rd(IDX_CH_ENABLE, 8'h0f);
  endtask : access_rules

  task automatic high_flag_and_irq();
    delay <= 4'h7;
    wr(IDX_R3_HIGH_UPPER, 8'h19);
    wr(IDX_R3_HIGH_LOWER, 8'h00);
    temps[63:48] <= 16'h1910;
    wait_conv(2'd3);
    rd(IDX_HIGH_STATUS, 8'h08);
    check({31'h0, alarm_pin}, 32'h0);
    rd(IDX_IRQ_STATUS, 8'h08);
    check({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 8'h08);
    @(posedge clk_sys);
    check({31'h0, irq}, 32'h1);
    temps[63:48] <= 16'h1900;
    wait_conv(2'd3);
    rd(IDX_HIGH_STATUS, 8'h00);
    check({31'h0, alarm_pin}, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STATUS, 8'h08);
    rd(IDX_IRQ_STATUS, 8'h00);
    check({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 8'h00);
  endtask : high_flag_and_irq

  task automatic low_flag_and_mask();
    delay <= 4'h0;
    temps[15:0] <= 16'hc8f0;
    wait_conv(2'd0);
    rd(IDX_LOW_STATUS, 8'h01);
    rd(IDX_IRQ_STATUS, 8'h10);
    check({31'h0, alarm_pin}, 32'h0);
    wr(IDX_ALARM_MASK, 8'h01);
    @(posedge clk_sys);
    check({31'h0, alarm_pin}, 32'h1);
    wr(IDX_ALARM_MASK, 8'h0e);
    @(posedge clk_sys);
    check({31'h0, alarm_pin}, 32'h0);
    temps[15:0] <= 16'hc900;
    wait_conv(2'd0);
    rd(IDX_LOW_STATUS, 8'h00);
    check({31'h0, alarm_pin}, 32'h1);
    wr(IDX_ALARM_MASK, 8'h00);
    wr(IDX_IRQ_STATUS, 8'hff);
    rd(IDX_IRQ_STATUS, 8'h00);
  endtask : low_flag_and_mask

  task automatic enable_and_fault();
    int good, bad;
    good = 0;
    bad = 0;
    wr(IDX_CH_ENABLE, 8'h08);
    wait_conv(2'd3);
    faults <= 4'b0010;
    repeat (80)
    begin
      @(posedge clk_sys);
      if (conv_start)
        if (conv_channel == 2'd3) good++; else bad++;
    end
    check(bad, 0);
    check({31'h0, good >= 4}, 32'h1);
    rd(IDX_DIODE_FAULT, 8'h00);
    wr(IDX_CH_ENABLE, 8'h0a);
    wait_conv(2'd1);
    rd(IDX_DIODE_FAULT, 8'h02);
    wr(IDX_CH_ENABLE, 8'h00);
    bad = 0;
    repeat (60)
    begin
      @(posedge clk_sys);
      if (conv_start) bad++;
    end
    check(bad, 0);
    faults <= 4'b0000;
    wr(IDX_CH_ENABLE, 8'h0f);
  endtask : enable_and_fault

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    temps = {4{16'h1000}};
    faults = 4'h0;
    delay = 4'h3;
    do_reset();
    reset_values();
    access_rules();
    high_flag_and_irq();
    low_flag_and_mask();
    enable_and_fault();
    do_reset();
    rd(IDX_R3_HIGH_UPPER, 8'h7f);
    rd(IDX_CH_ENABLE, 8'h0f);
    test_done();
  end
endmodule : thermal_limit_alarm_logic_bench
